// [src/ctm_params.svh]
// Constants for the instruction timing sequencer.
`ifndef CTM_PARAMS_SVH
`define CTM_PARAMS_SVH
// Cycles saved when a conditional branch is not taken.
`define CTM_NT_SAVE 5'h02
// Base and ceiling of a code byte read.
`define CTM_CRD_BASE 5'h04
`define CTM_CRD_MAX 5'h07
// Longest added flash read timing for a code byte read.
`define CTM_CRD_FRT_MAX 5'h02
// Spare opcode that behaves as no-operation.
`define CTM_ALT_NOP 8'ha5
// Cycles of an external data move.
`define CTM_EXT_CYC 5'h03
// Reset value of counters and captured values.
`define CTM_RST_CNT 5'h00
`define CTM_RST_ADDR 16'h0000
`endif

// [src/ctm_pkg.sv]
// Types shared by the instruction timing sequencer.
package ctm_pkg;
    // One instruction offered for execution.
    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic [15:0] pc;
        logic [7:0] rel;
        logic taken;
    } ctm_issue_t;
    // Debug requests arriving from the two-wire debug link decoder.
    typedef struct packed {
        logic halt;
        logic run;
        logic step;
        logic bp_en;
        logic [15:0] bp_addr;
    } ctm_dbg_t;
    // Decoded timing class of one opcode.
    typedef struct packed {
        logic [1:0] len;
        logic [4:0] cyc;
        logic branch;
        logic code_rd;
        logic ext_mv;
        logic ext_wr;
        logic data_pointer_form;
    } ctm_dec_t;
    // Sequencer states, one-hot.
    typedef enum logic [2:0] {
        CTM_IDLE = 3'b001,
        CTM_EXEC = 3'b010,
        CTM_HALT = 3'b100
    } ctm_state_t;
endpackage : ctm_pkg

// [src/ctm_timing.sv]
// Instruction timing sequencer with debug halt and flash write steering.
`timescale 1ns/1ps
`default_nettype none
`include "ctm_params.svh"

// Operation
// RULE1 - Decode opcodes with classic binary encoding
// RULE2 - Count durations in plain clock cycles
// RULE3 - Cycles equal bytes except listed cases
// RULE4 - Untaken branch finishes two cycles sooner
// RULE5 - Listed counts hold with prefetch enabled
// RULE6 - Add forms: register one, others two
// RULE7 - Logic to accumulator: register one, indirect two
// RULE8 - Logic to direct: two or three cycles
// RULE9 - Accumulator unary ops take one cycle
// RULE10 - Direct to direct move: three cycles
// RULE11 - Indirect and direct moves: two cycles
// RULE12 - Data pointer load: three bytes, three
// RULE13 - Code byte read takes four to seven
// RULE14 - External data move: one byte, three
// RULE15 - Push direct: two bytes, two cycles
// RULE16 - External write may write or erase flash
// RULE17 - Software reads and writes flash bytewise
// RULE18 - Debug and programming only via two-wire link
// RULE19 - Breakpoints, run, halt, single step supported
// RULE20 - Debug uses no application resources
// RULE21 - Relative offset added to next address
// RULE22 - Spare opcode acts as no-operation
// RULE23 - Add fetch latency when prefetch disabled
module ctm_timing (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire ctm_pkg::ctm_issue_t issue_in,
    input wire ctm_pkg::ctm_dbg_t dbg_in,
    input wire logic prefetch_enable_in,
    input wire logic [1:0] flash_read_timing_in,
    input wire logic flash_write_enable_in,
    input wire logic flash_erase_enable_in,
    output logic ready_out,
    output logic done_out,
    output logic [1:0] len_out,
    output logic [4:0] cyc_out,
    output logic [15:0] target_out,
    output logic code_rd_out,
    output logic external_data_space_wr_out,
    output logic flash_wr_out,
    output logic flash_erase_out,
    output logic halted_out,
    output logic [15:0] dbg_pc_out
);

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------

    // Builds one timing class entry.
    function automatic ctm_pkg::ctm_dec_t ctm_mk(input logic [1:0] l, input logic [4:0] c,
                                                input logic br);
        ctm_pkg::ctm_dec_t d;
        d = '0;
        d.len = l;
        d.cyc = c;
        d.branch = br;
        return d;
    endfunction : ctm_mk

    // Maps an opcode to its byte length and taken-path cycle count.
    function automatic ctm_pkg::ctm_dec_t ctm_decode(input logic [7:0] op);
        ctm_pkg::ctm_dec_t d;
        d = ctm_mk(2'h1, 5'h01, 1'b0);
        // RULE1 opcode map
        casez (op)
            // RULE22 spare no-operation
            `CTM_ALT_NOP: d = ctm_mk(2'h1, 5'h01, 1'b0);
            8'b????_0001: d = ctm_mk(2'h2, 5'h04, 1'b0);
            8'h02, 8'h12: d = ctm_mk(2'h3, 5'h05, 1'b0);
            8'h22, 8'h32: d = ctm_mk(2'h1, 5'h06, 1'b0);
            8'h73: d = ctm_mk(2'h1, 5'h04, 1'b0);
            8'h80: d = ctm_mk(2'h2, 5'h04, 1'b0);
            8'h10, 8'h20, 8'h30, 8'hb4, 8'hb5, 8'hd5: d = ctm_mk(2'h3, 5'h05, 1'b1);
            8'b1011_011?, 8'b1011_1???: d = ctm_mk(2'h3, 5'h05, 1'b1);
            8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1???: d = ctm_mk(2'h2, 5'h04, 1'b1);
            // RULE12 pointer load
            8'h90: d = ctm_mk(2'h3, 5'h03, 1'b0);
            // RULE8 logic to direct
            8'h43, 8'h53, 8'h63: d = ctm_mk(2'h3, 5'h03, 1'b0);
            // RULE10 direct to direct
            8'h75, 8'h85: d = ctm_mk(2'h3, 5'h03, 1'b0);
            // RULE13 code byte read
            8'h83, 8'h93: begin
                d = ctm_mk(2'h1, `CTM_CRD_BASE, 1'b0);
                d.code_rd = 1'b1;
            end
            // RULE14 external data move
            8'he0, 8'hf0, 8'b111?_001?: begin
                d = ctm_mk(2'h1, `CTM_EXT_CYC, 1'b0);
                d.ext_mv = 1'b1;
                d.ext_wr = op[4];
                d.data_pointer_form = ~op[1];
            end
            8'ha4: d = ctm_mk(2'h1, 5'h04, 1'b0);
            8'h84: d = ctm_mk(2'h1, 5'h08, 1'b0);
            // RULE6 immediate forms
            8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94: d = ctm_mk(2'h2, 5'h02, 1'b0);
            // Logic-to-direct with the accumulator, and the bit operations.
            8'h42, 8'h52, 8'h62, 8'h72, 8'b1???_0010: d = ctm_mk(2'h2, 5'h02, 1'b0);
            // RULE15 push and pop
            8'ha0, 8'hb0, 8'hc0, 8'hd0: d = ctm_mk(2'h2, 5'h02, 1'b0);
            8'b????_0101: d = ctm_mk(2'h2, 5'h02, 1'b0);
            // RULE11 indirect moves
            // The pointer increment in the 0xa_ row stays single-cycle, so it is left out here.
            8'b0111_????, 8'b1000_011?, 8'b1000_1???, 8'b1010_011?, 8'b1010_1???: begin
                d = ctm_mk(2'h2, 5'h02, 1'b0);
            end
            // RULE7 indirect operand
            8'b????_011?: d = ctm_mk(2'h1, 5'h02, 1'b0);
            // RULE9 single-cycle register and accumulator ops
            default: d = ctm_mk(2'h1, 5'h01, 1'b0);
        endcase
        return d;
    endfunction : ctm_decode

    // Final cycle count for one issued instruction.
    function automatic logic [4:0] ctm_cycles(input ctm_pkg::ctm_dec_t d, input logic taken,
                                              input logic align, input logic prefetch_enable,
                                              input logic [1:0] frt);
        logic [4:0] c;
        logic [4:0] f;
        f = {3'h0, frt};
        c = d.cyc;
        // RULE13 alignment and read timing stretch
        if (d.code_rd) begin
            c = c + {4'h0, align} + ((f > `CTM_CRD_FRT_MAX) ? `CTM_CRD_FRT_MAX : f);
        end
        // RULE4 untaken branch shortcut
        if (d.branch && !taken) begin
            c = c - `CTM_NT_SAVE;
        end
        // RULE23 flash wait states per fetched byte
        if (!prefetch_enable) begin
            c = c + f * {3'h0, d.len};
        end
        return c;
    endfunction : ctm_cycles

    // ----------------------------------------
    // Issue and sequencing
    // ----------------------------------------

    ctm_pkg::ctm_state_t state_ff; // Sequencer state.
    logic [4:0] cnt_ff; // Enabled cycles left in the running instruction.
    logic [4:0] run_cnt_ff; // Enabled cycles spent so far, compared by the duration check.
    logic step_ff; // One instruction is allowed out of halt.
    logic [1:0] wr_kind_ff; // Pending write: 1 external, 2 flash write, 3 flash erase.
    ctm_pkg::ctm_dec_t dec; // Decode of the offered opcode.
    logic [4:0] nxt_cyc; // Cycle count of the offered instruction.
    logic bp_hit; // Offered address matches the breakpoint.
    logic start; // Instruction accepted this cycle.
    logic finish; // Running instruction ends this cycle.

    assign dec = ctm_decode(issue_in.opcode);
    // RULE5 counts follow the prefetch setting
    assign nxt_cyc = ctm_cycles(dec, issue_in.taken, issue_in.pc[0], prefetch_enable_in,
                                flash_read_timing_in);
    // RULE19 breakpoint compare
    assign bp_hit = dbg_in.bp_en && (issue_in.pc == dbg_in.bp_addr) && !step_ff;
    assign start = ce_in && (state_ff == ctm_pkg::CTM_IDLE) && issue_in.valid && !bp_hit
                   && (!dbg_in.halt || step_ff);
    assign finish = ce_in && (state_ff == ctm_pkg::CTM_EXEC) && (cnt_ff == 5'h01);

    // State moves; halt is taken only between instructions so none is torn.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= ctm_pkg::CTM_IDLE;
        end else if (ce_in) begin
            unique case (state_ff)
                ctm_pkg::CTM_IDLE: begin
                    // RULE19 halt on request or breakpoint
                    if (start) begin
                        state_ff <= ctm_pkg::CTM_EXEC;
                    end else if (!step_ff && (dbg_in.halt || (issue_in.valid && bp_hit))) begin
                        state_ff <= ctm_pkg::CTM_HALT;
                    end
                end
                ctm_pkg::CTM_EXEC: begin
                    if (finish) begin
                        state_ff <= (dbg_in.halt || step_ff) ? ctm_pkg::CTM_HALT
                                                             : ctm_pkg::CTM_IDLE;
                    end
                end
                ctm_pkg::CTM_HALT: begin
                    // RULE18 link requests resume or step
                    if (dbg_in.run || dbg_in.step) begin
                        state_ff <= ctm_pkg::CTM_IDLE;
                    end
                end
            endcase
        end
    end

    // Single-step permit, raised leaving halt and dropped at the stepped finish.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            step_ff <= 1'b0;
        end else if (ce_in) begin
            if (state_ff == ctm_pkg::CTM_HALT && dbg_in.step && !dbg_in.run) begin
                step_ff <= 1'b1;
            end else if (finish) begin
                step_ff <= 1'b0;
            end
        end
    end

    // RULE2 cycle counter in system clocks
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_ff <= `CTM_RST_CNT;
            run_cnt_ff <= `CTM_RST_CNT;
        end else if (ce_in) begin
            if (start) begin
                cnt_ff <= nxt_cyc;
                // Counts completed execute cycles, so it equals the count at done.
                run_cnt_ff <= 5'h00;
            end else if (state_ff == ctm_pkg::CTM_EXEC) begin
                cnt_ff <= cnt_ff - 5'h01;
                run_cnt_ff <= run_cnt_ff + 5'h01;
            end
        end
    end

    // ----------------------------------------
    // Captured results
    // ----------------------------------------

    // Length, count, branch target and debug address captured at issue.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            len_out <= 2'h0;
            cyc_out <= `CTM_RST_CNT;
            target_out <= `CTM_RST_ADDR;
            code_rd_out <= 1'b0;
            dbg_pc_out <= `CTM_RST_ADDR;
        end else if (ce_in && start) begin
            // RULE3 length beside its cycle count
            len_out <= dec.len;
            cyc_out <= nxt_cyc;
            // RULE21 signed offset from next instruction
            target_out <= issue_in.pc + {14'h0000, dec.len} + {{8{issue_in.rel[7]}}, issue_in.rel};
            code_rd_out <= dec.code_rd;
            // RULE20 debug view kept in its own flops
            dbg_pc_out <= issue_in.pc;
        end
    end

    // RULE16 external write steered to flash
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_kind_ff <= 2'h0;
        end else if (ce_in && start) begin
            if (!dec.ext_wr) begin
                wr_kind_ff <= 2'h0;
            end else if (dec.data_pointer_form && flash_write_enable_in) begin
                wr_kind_ff <= flash_erase_enable_in ? 2'h3 : 2'h2;
            end else begin
                wr_kind_ff <= 2'h1;
            end
        end
    end

    // Completion strobes, one enabled cycle each; the write strobe rises with done, the cycle after the last.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            done_out <= 1'b0;
            external_data_space_wr_out <= 1'b0;
            flash_wr_out <= 1'b0;
            flash_erase_out <= 1'b0;
        end else if (ce_in) begin
            done_out <= finish;
            external_data_space_wr_out <= finish && (wr_kind_ff == 2'h1);
            // RULE17 bytewise flash write
            flash_wr_out <= finish && (wr_kind_ff == 2'h2);
            flash_erase_out <= finish && (wr_kind_ff == 2'h3);
        end
    end

    // Ready and halted views, registered from the current state.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ready_out <= 1'b0;
            halted_out <= 1'b0;
        end else if (ce_in) begin
            // Frozen with the rest of the state while the clock enable is low.
            ready_out <= (state_ff == ctm_pkg::CTM_IDLE) && !start;
            halted_out <= (state_ff == ctm_pkg::CTM_HALT);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence seq_issue(logic [7:0] op);
        start && issue_in.opcode == op;
    endsequence

    sequence seq_quiet;
        !dbg_in.run && !dbg_in.step;
    endsequence

    AST_DURATION: assert property (done_out |-> run_cnt_ff == cyc_out) // RULE2
        else $error("Duration differs from the captured cycle count.");
    AST_SPARE_NOP: assert property (seq_issue(8'ha5) and prefetch_enable_in
        |=> cyc_out == 5'h01 && len_out == 2'h1) // RULE22
        else $error("Spare opcode is not a one-cycle no-operation.");
    AST_UNTAKEN: assert property (start && dec.branch && !issue_in.taken && prefetch_enable_in
        |=> cyc_out == $past(dec.cyc) - 5'h02) // RULE4
        else $error("Untaken branch is not two cycles shorter.");
    AST_CODE_READ: assert property (start && dec.code_rd && prefetch_enable_in
        |=> cyc_out >= 5'h04 && cyc_out <= 5'h07) // RULE13
        else $error("Code byte read outside four to seven cycles.");
    AST_EXT_MOVE: assert property (start && dec.ext_mv && prefetch_enable_in
        |=> cyc_out == 5'h03 && len_out == 2'h1) // RULE14
        else $error("External data move is not one byte, three cycles.");
    AST_DIRECT_MOVE: assert property (seq_issue(8'h85) and prefetch_enable_in
        |=> cyc_out == 5'h03 && len_out == 2'h3) // RULE10
        else $error("Direct to direct move is not three bytes, three cycles.");
    AST_FLASH_WRITE: assert property (flash_wr_out |-> done_out && !external_data_space_wr_out) // RULE16
        else $error("Flash write strobe without completion.");
    AST_HALT_HOLD: assert property (halted_out && state_ff == ctm_pkg::CTM_HALT
        ##0 seq_quiet |=> !ready_out [*2]) // RULE19
        else $error("Core left halt without a link request.");
    AST_BREAKPOINT: assert property (ce_in && state_ff == ctm_pkg::CTM_IDLE && issue_in.valid
        && bp_hit |=> state_ff == ctm_pkg::CTM_HALT ##1 halted_out) // RULE19
        else $error("Breakpoint did not halt the core.");

endmodule : ctm_timing
`default_nettype wire

// [verif/ctm_dbg_host.sv]
// Debug host adapter model that drives the core's debug request inputs.
`timescale 1ns/1ps
`default_nettype none
module ctm_dbg_host (
    input wire logic clk_in,
    output var ctm_pkg::ctm_dbg_t dbg_out
);
    // --------------------------------------------------------------
    // Request drivers
    // --------------------------------------------------------------
    // link only path
    // The host reaches the core through these requests alone and holds no core state.
    initial dbg_out = '0;
    task automatic set_halt(input logic lvl);
        dbg_out.halt = lvl;
    endtask : set_halt
    // run or step
    // A slow host idles first; the request itself is always one cycle long.
    task automatic pulse(input logic is_run, input int slow);
        repeat (slow) @(negedge clk_in);
        dbg_out.run = is_run;
        dbg_out.step = !is_run;
        @(negedge clk_in);
        dbg_out.run = 1'b0;
        dbg_out.step = 1'b0;
    endtask : pulse
    task automatic set_bp(input logic en, input logic [15:0] addr);
        dbg_out.bp_en = en;
        dbg_out.bp_addr = addr;
    endtask : set_bp
endmodule : ctm_dbg_host
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the instruction timing sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // --------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------
    logic clk_in, rst_in, ce_in, prefetch_enable, fwe, fee;
    logic [1:0] frt, len_out;
    logic [4:0] cyc_out;
    logic [15:0] target_out, dbg_pc_out;
    logic ready_out, done_out, code_rd_out, external_data_space_wr_out, flash_wr_out, flash_erase_out;
    logic halted_out;
    logic [2:0] wr;
    ctm_pkg::ctm_issue_t issue;
    ctm_pkg::ctm_dbg_t dbg;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    ctm_timing dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .issue_in(issue),
        .dbg_in(dbg), .prefetch_enable_in(prefetch_enable), .flash_read_timing_in(frt),
        .flash_write_enable_in(fwe), .flash_erase_enable_in(fee), .ready_out(ready_out),
        .done_out(done_out), .len_out(len_out), .cyc_out(cyc_out), .target_out(target_out),
        .code_rd_out(code_rd_out), .external_data_space_wr_out(external_data_space_wr_out), .flash_wr_out(flash_wr_out),
        .flash_erase_out(flash_erase_out), .halted_out(halted_out), .dbg_pc_out(dbg_pc_out));
    ctm_dbg_host host (.clk_in(clk_in), .dbg_out(dbg));
    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic end_sim;
        if (errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Offers one instruction when idle and returns at the negedge that shows done.
    task automatic exec(input logic [7:0] op, input logic [15:0] pc, input logic [7:0] rel,
        input logic tk, input logic [1:0] ln, input logic [4:0] cy);
        int n;
        issue = '{1'b1, op, pc, rel, tk};
        @(posedge clk_in);
        @(negedge clk_in);
        issue.valid = 1'b0;
        chk(16'(len_out), 16'(ln));
        chk(16'(cyc_out), 16'(cy));
        chk(target_out, pc + 16'(ln) + {{8{rel[7]}}, rel});
        n = 0;
        while (done_out !== 1'b1 && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        chk(16'(n), 16'(cy));
        wr = {external_data_space_wr_out, flash_wr_out, flash_erase_out};
    endtask : exec
    // Table entry: opcode, then byte length nibble, then cycle nibble.
    task automatic run(input logic [15:0] e);
        exec(e[15:8], 16'h0100, 8'h00, 1'b0, e[5:4], {1'b0, e[3:0]});
    endtask : run
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_arith;
        logic [15:0] t [12] = '{16'h2811, 16'h2522, 16'h2612, 16'h2422, 16'h3811, 16'h3522,
            16'h3612, 16'h3422, 16'h9811, 16'h9522, 16'h9612, 16'h9422};
        foreach (t[i]) run(t[i]);
    endtask : t_arith
    task automatic t_logic;
        logic [15:0] a [6] = '{16'h5811, 16'h5612, 16'h4811, 16'h4612, 16'h6811, 16'h6612};
        logic [15:0] d [6] = '{16'h5222, 16'h5333, 16'h4222, 16'h4333, 16'h6222, 16'h6333};
        foreach (a[i]) run(a[i]);
        foreach (d[i]) run(d[i]);
    endtask : t_logic
    task automatic t_unary;
        logic [15:0] t [7] = '{16'he411, 16'hf411, 16'h2311, 16'h3311, 16'h0311, 16'h1311,
            16'hc411};
        foreach (t[i]) run(t[i]);
        run(16'h0011);
        run(16'ha511);
    endtask : t_unary
    task automatic t_moves;
        logic [15:0] t [5] = '{16'he213, 16'hf213, 16'he013, 16'hf013, 16'hc022};
        run(16'h8533);
        run(16'h8622);
        run(16'ha622);
        run(16'h7622);
        run(16'h9033);
        foreach (t[i]) run(t[i]);
    endtask : t_moves
    task automatic t_branch;
        exec(8'h40, 16'h0300, 8'hfe, 1'b1, 2'h2, 5'h04);
        exec(8'h40, 16'h0300, 8'hfe, 1'b0, 2'h2, 5'h02);
        exec(8'h20, 16'h0310, 8'h10, 1'b1, 2'h3, 5'h05);
        exec(8'h20, 16'h0310, 8'h10, 1'b0, 2'h3, 5'h03);
    endtask : t_branch
    task automatic t_code_rd;
        for (int p = 0; p < 2; p++) begin
            for (int f = 0; f < 4; f++) begin
                frt = f[1:0];
                exec(8'h93, 16'h0400 + 16'(p), 8'h00, 1'b0, 2'h1, 5'(4 + p + (f > 2 ? 2 : f)));
                chk(16'(code_rd_out), 16'h0001);
                exec(8'h83, 16'h0400 + 16'(p), 8'h00, 1'b0, 2'h1, 5'(4 + p + (f > 2 ? 2 : f)));
            end
        end
        frt = 2'h0;
        run(16'h0011);
        chk(16'(code_rd_out), 16'h0000);
    endtask : t_code_rd
    task automatic t_flash;
        run(16'hf013);
        chk(16'(wr), 16'h0004);
        fwe = 1'b1;
        run(16'hf013);
        chk(16'(wr), 16'h0002);
        fee = 1'b1;
        run(16'hf013);
        chk(16'({wr[2], wr[0]}), 16'h0001);
        run(16'hf213);
        chk(16'(wr), 16'h0004);
        fwe = 1'b0;
        fee = 1'b0;
    endtask : t_flash
    task automatic t_pref;
        prefetch_enable = 1'b0;
        frt = 2'h1;
        run(16'h2524);
        frt = 2'h2;
        run(16'h8539);
        frt = 2'h0;
        run(16'h2811);
        prefetch_enable = 1'b1;
    endtask : t_pref
    task automatic t_debug;
        int cnt;
        host.set_halt(1'b1);
        repeat (3) @(negedge clk_in);
        chk(16'(halted_out), 16'h0001);
        issue = '{1'b1, 8'h00, 16'h0200, 8'h00, 1'b0};
        cnt = 0;
        repeat (6) begin
            @(negedge clk_in);
            if (done_out === 1'b1) cnt++;
        end
        chk(16'(cnt), 16'h0000);
        host.pulse(1'b0, 2);
        repeat (8) begin
            @(negedge clk_in);
            if (done_out === 1'b1) cnt++;
        end
        chk(16'(cnt), 16'h0001);
        chk(dbg_pc_out, 16'h0200);
        chk(16'(halted_out), 16'h0001);
        issue.valid = 1'b0;
        host.set_halt(1'b0);
        host.pulse(1'b1, 0);
        repeat (2) @(negedge clk_in);
        chk(16'(halted_out), 16'h0000);
        host.set_bp(1'b1, 16'h0500);
        issue = '{1'b1, 8'h00, 16'h0500, 8'h00, 1'b0};
        repeat (5) @(negedge clk_in);
        chk(dbg_pc_out, 16'h0200);
        chk(16'(halted_out), 16'h0001);
        host.set_bp(1'b0, 16'h0000);
        host.pulse(1'b1, 0);
        exec(8'h00, 16'h0500, 8'h00, 1'b0, 2'h1, 5'h01);
        chk(dbg_pc_out, 16'h0500);
    endtask : t_debug
    // --------------------------------------------------------------
    // Clock, watchdog and main sequence
    // --------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // The ceiling is far above the few hundred cycles the scenarios need.
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        rst_in = 1'b1;
        ce_in = 1'b1;
        prefetch_enable = 1'b1;
        frt = 2'h0;
        fwe = 1'b0;
        fee = 1'b0;
        issue = '0;
        repeat (12) @(negedge clk_in);
        chk(16'(ready_out), 16'h0000);
        rst_in = 1'b0;
        @(negedge clk_in);
        chk(16'(ready_out), 16'h0001);
        t_arith();
        t_logic();
        t_unary();
        t_moves();
        t_branch();
        t_code_rd();
        t_flash();
        t_pref();
        t_debug();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
